// *** tcmux_pkg.sv ***
package tcmux_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_VIDEO_GAIN = 8'h04;
  localparam logic [7:0] ADDR_USB_GAIN = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;

  // Config register fields
  localparam int USB_EN_BIT = 0;
  localparam int DP_EN_BIT = 1;
  localparam int ORIENT_BIT = 2;
  localparam int AUX_OVR_LSB = 4;

  // Gain register fields, four bits each
  localparam int GAIN_W = 4;
  localparam int VID0_LSB = 0;
  localparam int VID1_LSB = 4;
  localparam int VID2_LSB = 8;
  localparam int VID3_LSB = 12;
  localparam int DN1_LSB = 0;
  localparam int DN2_LSB = 4;
  localparam int UP_LSB = 8;

  // Reset values
  localparam logic [31:0] CONFIG_RST = 32'h0000_0001;
  localparam logic [3:0] GAIN_RST = 4'h0;

  // Aux override codes
  localparam logic [1:0] AUX_AUTO = 2'h0;
  localparam logic [1:0] AUX_STRAIGHT = 2'h1;
  localparam logic [1:0] AUX_SWAPPED = 2'h2;
  localparam logic [1:0] AUX_OPEN = 2'h3;

  // Sustained idle before U1 drops to U2/U3
  localparam int U1_IDLE_US = 300;
  localparam int CLK_MHZ = 25;
  localparam int U1_IDLE_CYC = U1_IDLE_US * CLK_MHZ;
  // Period of far-end termination tests in U2/U3
  localparam int RXDET_US = 100;
  localparam int RXDET_CYC = RXDET_US * CLK_MHZ;
  localparam int CNT_W = 16;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    LINK_DISC = 4'h1,
    LINK_U0 = 4'h2,
    LINK_U1 = 4'h4,
    LINK_U23 = 4'h8
  } tcmux_link_e;

  typedef enum logic [2:0] {
    MODE_OFF = 3'h0,
    MODE_USB = 3'h1,
    MODE_DP4 = 3'h2,
    MODE_USBDP = 3'h3
  } tcmux_mode_e;

  typedef enum logic [1:0] {
    SB_OPEN = 2'h0,
    SB_STRAIGHT = 2'h1,
    SB_SWAPPED = 2'h2
  } tcmux_sb_e;

  // Observed per-port line conditions
  typedef struct packed {
    logic termPresent;
    logic elecIdle;
    logic lfps;
    logic ssActive;
  } tcmux_line_s;

  // Gain per receiver lane
  typedef struct packed {
    logic [3:0] video0;
    logic [3:0] video1;
    logic [3:0] video2;
    logic [3:0] video3;
    logic [3:0] down1;
    logic [3:0] down2;
    logic [3:0] up;
  } tcmux_gain_s;

  // Analog controls per link state
  typedef struct packed {
    logic redrive;
    logic rxTerm;
    logic txCommonMode;
    logic rxDetect;
    logic [1:0] powerLevel;
  } tcmux_ana_s;

endpackage : tcmux_pkg

// *** tcmux_ctrl.sv ***
// Contract
// [RULE_01] Any non-low select pin takes lane configuration from register fields.
// [RULE_02] Enable fields decode: 00 off, 01 USB, 10 four video, 11 both.
// [RULE_03] Automatic aux: straight unflipped, swapped flipped, open without video.
// [RULE_04] Aux override beats config: 01 straight, 10 swapped, 11 open.
// [RULE_05] Video enable comes from pin in pin mode, else from register.
// [RULE_06] Each receiver lane has its own independent gain setting; pin mode shares one setting per pin pair.
// [RULE_07] Pin gain index is four times upper level plus lower level.
// [RULE_08] Register mode gives separate gain fields for all seven receiver lanes.
// [RULE_09] Link tracking runs only while USB is enabled.
// [RULE_10] Link state derives from termination, idle, LFPS and signaling rate.
// [RULE_11] Disconnect waits for termination on both ports, then goes to U0.
// [RULE_12] U0 redrives traffic on both ports.
// [RULE_13] U0 goes to U1 once both ports are electrically idle.
// [RULE_14] U1 keeps terminations and transmitter common mode enabled.
// [RULE_15] U2/U3 tests termination periodically; absence on either port disconnects.
// [RULE_16] U2/U3 goes to U0 on valid LFPS.
// [RULE_17] U2/U3 keeps terminations but drops transmitter common mode.
// [RULE_18] Power rises: Disconnect, U2/U3, U1, U0.
// [RULE_19] U1 goes to U2/U3 on sustained idle, to U0 on activity.
module tcmux_ctrl #(
  parameter int U1_IDLE_CYCLES = tcmux_pkg::U1_IDLE_CYC,
  parameter int RXDET_CYCLES = tcmux_pkg::RXDET_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [1:0] registerSelectLevel,
  input wire logic displayportEnablePin,
  input wire logic usbEnablePin,
  input wire logic orientationPin,
  input wire logic [1:0] downstreamGainPinHi,
  input wire logic [1:0] downstreamGainPinLo,
  input wire logic [1:0] upstreamGainPinHi,
  input wire logic [1:0] upstreamGainPinLo,
  input wire logic [1:0] videoLaneGainPinHi,
  input wire logic [1:0] videoLaneGainPinLo,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdata,
  input wire tcmux_pkg::tcmux_line_s upLine,
  input wire tcmux_pkg::tcmux_line_s downLine,
  output tcmux_pkg::tcmux_mode_e laneMode,
  output logic flipped,
  output tcmux_pkg::tcmux_sb_e sidebandMap,
  output tcmux_pkg::tcmux_gain_s rxGain,
  output tcmux_pkg::tcmux_link_e linkState,
  output tcmux_pkg::tcmux_ana_s analogCtrl,
  output logic rxDetectPulse
);

  typedef struct packed {
    logic [31:0] cfg;
    logic [15:0] videoGain;
    logic [11:0] usbGain;
    logic [31:0] rdata;
    tcmux_pkg::tcmux_link_e link;
    logic [tcmux_pkg::CNT_W-1:0] idleCnt;
    logic [tcmux_pkg::CNT_W-1:0] detCnt;
    logic detPulse;
    tcmux_pkg::tcmux_mode_e mode;
    logic flip;
    tcmux_pkg::tcmux_sb_e sb;
    tcmux_pkg::tcmux_gain_s gain;
  } tcmux_state_s;

  tcmux_state_s state_q;
  tcmux_state_s state_d;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] pinGain(input logic [1:0] hi, input logic [1:0] lo);
    // [RULE_07] Pin pair index
    pinGain = {hi, lo};
  endfunction : pinGain

  function automatic tcmux_pkg::tcmux_mode_e decodeMode(input logic dp, input logic usb);
    // [RULE_02] Enable decode
    decodeMode = tcmux_pkg::tcmux_mode_e'({1'b0, dp, usb});
  endfunction : decodeMode

  function automatic tcmux_pkg::tcmux_sb_e sbMap(input logic [1:0] ovr, input logic dp,
                                                  input logic flip);
    // [RULE_04] Override first
    if (ovr == tcmux_pkg::AUX_STRAIGHT) begin
      sbMap = tcmux_pkg::SB_STRAIGHT;
    end else if (ovr == tcmux_pkg::AUX_SWAPPED) begin
      sbMap = tcmux_pkg::SB_SWAPPED;
    end else if (ovr == tcmux_pkg::AUX_OPEN) begin
      sbMap = tcmux_pkg::SB_OPEN;
    // [RULE_03] Automatic mapping
    end else if (!dp) begin
      sbMap = tcmux_pkg::SB_OPEN;
    end else if (flip) begin
      sbMap = tcmux_pkg::SB_SWAPPED;
    end else begin
      sbMap = tcmux_pkg::SB_STRAIGHT;
    end
  endfunction : sbMap

  logic regMode;
  logic dpEn;
  logic usbEn;
  logic orient;
  logic bothTerm;
  logic bothIdle;
  logic anyLfps;
  logic anyActive;

  // [RULE_01] Register mode select
  assign regMode = (registerSelectLevel != 2'h0);
  // [RULE_05] Video enable source
  assign dpEn = regMode ? state_q.cfg[tcmux_pkg::DP_EN_BIT] : displayportEnablePin;
  assign usbEn = regMode ? state_q.cfg[tcmux_pkg::USB_EN_BIT] : usbEnablePin;
  assign orient = regMode ? state_q.cfg[tcmux_pkg::ORIENT_BIT] : orientationPin;
  // [RULE_10] Line observations
  assign bothTerm = upLine.termPresent & downLine.termPresent;
  assign bothIdle = upLine.elecIdle & downLine.elecIdle;
  assign anyLfps = upLine.lfps | downLine.lfps;
  assign anyActive = upLine.ssActive | downLine.ssActive;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    state_d.detPulse = 1'b0;
    state_d.rdata = 32'h0000_0000;
    // Register writes
    if (regWrite) begin
      if (regAddr == tcmux_pkg::ADDR_CONFIG) begin
        state_d.cfg = {26'h0, regWdata[5:4], 1'b0, regWdata[2:0]};
      end else if (regAddr == tcmux_pkg::ADDR_VIDEO_GAIN) begin
        state_d.videoGain = regWdata[15:0];
      end else if (regAddr == tcmux_pkg::ADDR_USB_GAIN) begin
        state_d.usbGain = regWdata[11:0];
      end
    end
    // Register reads
    if (regRead) begin
      if (regAddr == tcmux_pkg::ADDR_CONFIG) begin
        state_d.rdata = state_q.cfg;
      end else if (regAddr == tcmux_pkg::ADDR_VIDEO_GAIN) begin
        state_d.rdata = {16'h0, state_q.videoGain};
      end else if (regAddr == tcmux_pkg::ADDR_USB_GAIN) begin
        state_d.rdata = {20'h0, state_q.usbGain};
      end else if (regAddr == tcmux_pkg::ADDR_STATUS) begin
        state_d.rdata = {21'h0, state_q.sb, state_q.flip, 1'b0, state_q.mode, state_q.link};
      end
    end
    // [RULE_01] Same configurations both modes
    state_d.mode = decodeMode(dpEn, usbEn);
    state_d.flip = orient;
    state_d.sb = regMode
      ? sbMap(state_q.cfg[tcmux_pkg::AUX_OVR_LSB +: 2], dpEn, orient)
      : sbMap(tcmux_pkg::AUX_AUTO, dpEn, orient);
    // [RULE_06] Lane gains, independent in register mode, shared per pin pair in pin mode
    if (regMode) begin
      // [RULE_08] Per-lane fields
      state_d.gain.video0 = state_q.videoGain[tcmux_pkg::VID0_LSB +: tcmux_pkg::GAIN_W];
      state_d.gain.video1 = state_q.videoGain[tcmux_pkg::VID1_LSB +: tcmux_pkg::GAIN_W];
      state_d.gain.video2 = state_q.videoGain[tcmux_pkg::VID2_LSB +: tcmux_pkg::GAIN_W];
      state_d.gain.video3 = state_q.videoGain[tcmux_pkg::VID3_LSB +: tcmux_pkg::GAIN_W];
      state_d.gain.down1 = state_q.usbGain[tcmux_pkg::DN1_LSB +: tcmux_pkg::GAIN_W];
      state_d.gain.down2 = state_q.usbGain[tcmux_pkg::DN2_LSB +: tcmux_pkg::GAIN_W];
      state_d.gain.up = state_q.usbGain[tcmux_pkg::UP_LSB +: tcmux_pkg::GAIN_W];
    end else begin
      state_d.gain.video0 = pinGain(videoLaneGainPinHi, videoLaneGainPinLo);
      state_d.gain.video1 = pinGain(videoLaneGainPinHi, videoLaneGainPinLo);
      state_d.gain.video2 = pinGain(videoLaneGainPinHi, videoLaneGainPinLo);
      state_d.gain.video3 = pinGain(videoLaneGainPinHi, videoLaneGainPinLo);
      state_d.gain.down1 = pinGain(downstreamGainPinHi, downstreamGainPinLo);
      state_d.gain.down2 = pinGain(downstreamGainPinHi, downstreamGainPinLo);
      state_d.gain.up = pinGain(upstreamGainPinHi, upstreamGainPinLo);
    end
    // Link state tracking
    state_d.idleCnt = '0;
    state_d.detCnt = '0;
    // [RULE_09] Only with USB enabled
    if (!usbEn) begin
      state_d.link = tcmux_pkg::LINK_DISC;
    end else begin
      case (state_q.link)
        tcmux_pkg::LINK_DISC: begin
          // [RULE_11] Termination on both
          if (bothTerm) begin
            state_d.link = tcmux_pkg::LINK_U0;
          end
        end
        tcmux_pkg::LINK_U0: begin
          // [RULE_13] Both idle
          if (bothIdle) begin
            state_d.link = tcmux_pkg::LINK_U1;
          end
        end
        tcmux_pkg::LINK_U1: begin
          // [RULE_19] U1 exits
          if (anyLfps || anyActive || !bothIdle) begin
            state_d.link = tcmux_pkg::LINK_U0;
          end else if (32'(state_q.idleCnt) >= U1_IDLE_CYCLES - 1) begin
            state_d.link = tcmux_pkg::LINK_U23;
          end else begin
            state_d.idleCnt = state_q.idleCnt + 1'b1;
          end
        end
        tcmux_pkg::LINK_U23: begin
          // [RULE_16] LFPS wakes
          if (anyLfps) begin
            state_d.link = tcmux_pkg::LINK_U0;
          // [RULE_15] Periodic detect
          end else if (32'(state_q.detCnt) >= RXDET_CYCLES - 1) begin
            state_d.detPulse = 1'b1;
            if (!bothTerm) begin
              state_d.link = tcmux_pkg::LINK_DISC;
            end
          end else begin
            state_d.detCnt = state_q.detCnt + 1'b1;
          end
        end
        default: begin
          state_d.link = tcmux_pkg::LINK_DISC;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q <= '{cfg: tcmux_pkg::CONFIG_RST, videoGain: 16'h0, usbGain: 12'h0,
                   rdata: 32'h0, link: tcmux_pkg::LINK_DISC, idleCnt: '0, detCnt: '0,
                   detPulse: 1'b0, mode: tcmux_pkg::MODE_OFF, flip: 1'b0,
                   sb: tcmux_pkg::SB_OPEN, gain: '0};
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign regRdata = state_q.rdata;
  assign laneMode = state_q.mode;
  assign flipped = state_q.flip;
  assign sidebandMap = state_q.sb;
  assign rxGain = state_q.gain;
  assign linkState = state_q.link;
  assign rxDetectPulse = state_q.detPulse;

  // Analog controls per state
  always_comb begin
    analogCtrl = '0;
    case (state_q.link)
      tcmux_pkg::LINK_U0: begin
        // [RULE_12] Redrive both ports
        analogCtrl.redrive = 1'b1;
        analogCtrl.rxTerm = 1'b1;
        analogCtrl.txCommonMode = 1'b1;
        // [RULE_18] Highest power
        analogCtrl.powerLevel = 2'h3;
      end
      tcmux_pkg::LINK_U1: begin
        // [RULE_14] Terms and common mode
        analogCtrl.rxTerm = 1'b1;
        analogCtrl.txCommonMode = 1'b1;
        analogCtrl.powerLevel = 2'h2;
      end
      tcmux_pkg::LINK_U23: begin
        // [RULE_17] Terms without common mode
        analogCtrl.rxTerm = 1'b1;
        analogCtrl.rxDetect = 1'b1;
        analogCtrl.powerLevel = 2'h1;
      end
      default: begin
        analogCtrl.rxDetect = 1'b1;
      end
    endcase
  end

endmodule : tcmux_ctrl

// *** tcmux_ctrl_assertions.sv ***
module tcmux_ctrl_chk #(
  parameter int U1_IDLE_CYCLES = 4,
  parameter int RXDET_CYCLES = 4
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [1:0] registerSelectLevel,
  input wire logic displayportEnablePin,
  input wire logic usbEnablePin,
  input wire logic orientationPin,
  input wire tcmux_pkg::tcmux_line_s upLine,
  input wire tcmux_pkg::tcmux_line_s downLine,
  input wire tcmux_pkg::tcmux_mode_e laneMode,
  input wire logic flipped,
  input wire tcmux_pkg::tcmux_sb_e sidebandMap,
  input wire tcmux_pkg::tcmux_link_e linkState,
  input wire tcmux_pkg::tcmux_ana_s analogCtrl
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int IDLE_MAX = U1_IDLE_CYCLES + 3;
  localparam int DET_MAX = RXDET_CYCLES + 3;
  logic pinUsb;
  logic bothTerm;
  logic bothIdle;
  assign pinUsb = registerSelectLevel == 2'h0 && usbEnablePin;
  assign bothTerm = upLine.termPresent && downLine.termPresent;
  assign bothIdle = upLine.elecIdle && downLine.elecIdle;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_pin_mode: assert property (
    registerSelectLevel == 2'h0 && $past(registerSelectLevel) == 2'h0 && !$past(rst)
    |-> laneMode == {1'b0, $past(displayportEnablePin), $past(usbEnablePin)})
    else $error("lane mode does not follow pins");
  a_pin_aux: assert property (
    registerSelectLevel == 2'h0 && $past(registerSelectLevel) == 2'h0 && !$past(rst)
    |-> flipped == $past(orientationPin) && sidebandMap == (!$past(displayportEnablePin) ?
    tcmux_pkg::SB_OPEN : ($past(orientationPin) ? tcmux_pkg::SB_SWAPPED : tcmux_pkg::SB_STRAIGHT)))
    else $error("sideband map wrong in pin mode");
  a_disc_exit: assert property (
    linkState == tcmux_pkg::LINK_DISC && pinUsb && bothTerm |=> linkState == tcmux_pkg::LINK_U0)
    else $error("disconnect did not go to U0");
  a_u0_idle: assert property (
    linkState == tcmux_pkg::LINK_U0 && pinUsb && bothIdle |=> linkState == tcmux_pkg::LINK_U1)
    else $error("U0 did not go to U1");
  a_u1_sleep: assert property (
    linkState == tcmux_pkg::LINK_U1 && bothIdle |-> ##[1:IDLE_MAX] linkState != tcmux_pkg::LINK_U1)
    else $error("U1 held too long under idle");
  a_u23_wake: assert property (
    linkState == tcmux_pkg::LINK_U23 && pinUsb && bothTerm && upLine.lfps && downLine.lfps
    |=> linkState == tcmux_pkg::LINK_U0)
    else $error("U2/U3 did not wake on LFPS");
  a_u23_drop: assert property (
    linkState == tcmux_pkg::LINK_U23 && pinUsb && !downLine.termPresent
    |-> ##[1:DET_MAX] linkState == tcmux_pkg::LINK_DISC)
    else $error("lost termination not seen");
  a_usb_off: assert property (
    registerSelectLevel == 2'h0 && !usbEnablePin |=> linkState == tcmux_pkg::LINK_DISC)
    else $error("tracking ran with USB off");
  a_u1_analog: assert property (
    linkState == tcmux_pkg::LINK_U1 |-> analogCtrl.rxTerm && analogCtrl.txCommonMode)
    else $error("U1 analog controls wrong");
  a_u23_analog: assert property (
    linkState == tcmux_pkg::LINK_U23 |-> analogCtrl.rxTerm && !analogCtrl.txCommonMode)
    else $error("U2/U3 analog controls wrong");
  a_u0_redrive: assert property (
    linkState == tcmux_pkg::LINK_U0 |-> analogCtrl.redrive && analogCtrl.rxTerm)
    else $error("U0 does not redrive both ports");
  a_power_order: assert property (
    analogCtrl.powerLevel == (linkState == tcmux_pkg::LINK_U0 ? 2'h3 :
    linkState == tcmux_pkg::LINK_U1 ? 2'h2 : linkState == tcmux_pkg::LINK_U23 ? 2'h1 : 2'h0))
    else $error("power level out of order");
endmodule : tcmux_ctrl_chk

bind tcmux_ctrl tcmux_ctrl_chk #(
  .U1_IDLE_CYCLES(U1_IDLE_CYCLES),
  .RXDET_CYCLES(RXDET_CYCLES)
) uChk (
  .ref_clk, .rst, .registerSelectLevel, .displayportEnablePin, .usbEnablePin,
  .orientationPin, .upLine, .downLine, .laneMode, .flipped, .sidebandMap, .linkState,
  .analogCtrl
);

// *** tcmux_usb_peer.sv ***
module tcmux_usb_peer (
  input wire logic ref_clk,
  input wire logic [2:0] phase,
  output tcmux_pkg::tcmux_line_s upLine,
  output tcmux_pkg::tcmux_line_s downLine
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Far-end line conditions: term, idle, lfps, active
  // ----------------------------------------------------------------
  // Observed conditions
  always @(posedge ref_clk) begin
    case (phase)
      3'h1: {upLine, downLine} <= 8'h99;
      3'h2: {upLine, downLine} <= 8'hcc;
      3'h3: {upLine, downLine} <= 8'haa;
      3'h4: {upLine, downLine} <= 8'hc4;
      default: {upLine, downLine} <= 8'h44;
    endcase
  end
endmodule : tcmux_usb_peer

// *** tcmux_ctrl_tb_top.sv ***
module tcmux_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int IDLE_N = 8;
  localparam int DET_N = 4;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] selLevel = 2'h0;
  logic dpPin = 1'b0;
  logic usbPin = 1'b0;
  logic flipPin = 1'b0;
  logic [11:0] gainPins = 12'h0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [31:0] regRdata;
  logic [2:0] phase = 3'h0;
  logic rxDetectPulse;
  tcmux_pkg::tcmux_line_s upLine;
  tcmux_pkg::tcmux_line_s downLine;
  tcmux_pkg::tcmux_mode_e laneMode;
  logic flipped;
  tcmux_pkg::tcmux_sb_e sidebandMap;
  tcmux_pkg::tcmux_gain_s rxGain;
  tcmux_pkg::tcmux_link_e linkState;
  logic [31:0] seed = 32'hd40b46a6;
  int fails = 0;
  int checkCount = 0;
  int cyc = 0;
  int pulses = 0;

  always #20 ref_clk = ~ref_clk;

  tcmux_ctrl #(.U1_IDLE_CYCLES(IDLE_N), .RXDET_CYCLES(DET_N)) uut (
    .ref_clk(ref_clk), .rst(rst), .registerSelectLevel(selLevel),
    .displayportEnablePin(dpPin), .usbEnablePin(usbPin), .orientationPin(flipPin),
    .downstreamGainPinHi(gainPins[11:10]), .downstreamGainPinLo(gainPins[9:8]),
    .upstreamGainPinHi(gainPins[7:6]), .upstreamGainPinLo(gainPins[5:4]),
    .videoLaneGainPinHi(gainPins[3:2]), .videoLaneGainPinLo(gainPins[1:0]),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .upLine(upLine), .downLine(downLine), .laneMode(laneMode),
    .flipped(flipped), .sidebandMap(sidebandMap), .rxGain(rxGain), .linkState(linkState),
    .analogCtrl(), .rxDetectPulse(rxDetectPulse)
  );

  tcmux_usb_peer uPeer (.ref_clk(ref_clk), .phase(phase), .upLine(upLine), .downLine(downLine));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  function automatic logic [1:0] sbExp(input logic dp, input logic fl, input logic [1:0] ovr);
    if (ovr != tcmux_pkg::AUX_AUTO) return (ovr == tcmux_pkg::AUX_OPEN) ? 2'h0 : ovr;
    return !dp ? tcmux_pkg::SB_OPEN : (fl ? tcmux_pkg::SB_SWAPPED : tcmux_pkg::SB_STRAIGHT);
  endfunction : sbExp

  task automatic test_done();
    $display("checks %0d mismatches %0d", checkCount, fails);
    if (fails == 0 && checkCount > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge ref_clk);
    regWrite <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge ref_clk);
    regRead <= 1'b0;
    #1;
    chk(regRdata, e);
  endtask : rd

  task automatic go(input logic [2:0] p, input int n);
    @(posedge ref_clk);
    phase <= p;
    tick(n);
  endtask : go

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (rxDetectPulse === 1'b1) pulses <= pulses + 1;
    if (cyc == 3000) begin
      fails++;
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    tick(1);
    chk(linkState, tcmux_pkg::LINK_DISC);
    rd(tcmux_pkg::ADDR_CONFIG, tcmux_pkg::CONFIG_RST);
    for (int i = 0; i < 8; i++) begin
      @(posedge ref_clk);
      {dpPin, usbPin, flipPin} <= i[2:0];
      tick(3);
      chk(laneMode, {1'b0, i[2:1]});
      chk(flipped, i[0]);
      chk(sidebandMap, sbExp(i[2], i[0], 2'h0));
    end
    for (int i = 0; i < 16; i++) begin
      seed = lfsr(seed);
      @(posedge ref_clk);
      gainPins <= seed[11:0];
      tick(3);
      chk(rxGain, {{4{seed[3:0]}}, {2{seed[11:8]}}, seed[7:4]});
    end
    for (int i = 0; i < 32; i++) begin
      seed = lfsr(seed);
      @(posedge ref_clk);
      selLevel <= (seed[1:0] == 2'h0) ? 2'h2 : seed[1:0];
      {dpPin, usbPin, flipPin} <= ~i[2:0];
      wr(tcmux_pkg::ADDR_CONFIG, {26'h0, i[4:3], 1'b0, i[2:0]});
      tick(3);
      chk(laneMode, {1'b0, i[1:0]});
      chk(flipped, i[2]);
      chk(sidebandMap, sbExp(i[1], i[2], i[4:3]));
    end
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      wr(tcmux_pkg::ADDR_VIDEO_GAIN, {16'h0, seed[15:0]});
      wr(tcmux_pkg::ADDR_USB_GAIN, {20'h0, seed[27:16]});
      tick(3);
      chk(rxGain, {seed[3:0], seed[7:4], seed[11:8], seed[15:12],
        seed[19:16], seed[23:20], seed[27:24]});
      rd(tcmux_pkg::ADDR_VIDEO_GAIN, {16'h0, seed[15:0]});
    end
    wr(8'h10, 32'hffff_ffff);
    rd(8'h10, 32'h0);
    rd(tcmux_pkg::ADDR_USB_GAIN, {20'h0, seed[27:16]});
    @(posedge ref_clk);
    selLevel <= 2'h0;
    {dpPin, usbPin, flipPin} <= 3'b010;
    go(3'h1, 4);
    chk(linkState, tcmux_pkg::LINK_U0);
    go(3'h2, 3);
    chk(linkState, tcmux_pkg::LINK_U1);
    go(3'h1, 3);
    chk(linkState, tcmux_pkg::LINK_U0);
    go(3'h2, IDLE_N + 6);
    chk(linkState, tcmux_pkg::LINK_U23);
    tick(DET_N + 3);
    chk(pulses != 0, 1'b1);
    go(3'h3, 3);
    chk(linkState, tcmux_pkg::LINK_U0);
    go(3'h2, IDLE_N + 6);
    go(3'h4, DET_N + 6);
    chk(linkState, tcmux_pkg::LINK_DISC);
    go(3'h1, 4);
    rd(tcmux_pkg::ADDR_STATUS, {21'h0, tcmux_pkg::SB_OPEN, 1'b0, 1'b0, tcmux_pkg::MODE_USB,
      tcmux_pkg::LINK_U0});
    @(posedge ref_clk);
    usbPin <= 1'b0;
    tick(3);
    chk(linkState, tcmux_pkg::LINK_DISC);
    test_done();
  end
endmodule : tcmux_ctrl_tb_top
